// ### common/lkd_defines.svh
// constants for the lock detect and enable register bank
`ifndef LKD_DEFINES_SVH
`define LKD_DEFINES_SVH
// ------------------------------------------------------------
// register map
// ------------------------------------------------------------
`define LKD_ADDR_LOCK 6'h07
`define LKD_ADDR_ENABLE 6'h08
`define LKD_LOCK_RST 24'h00014d
`define LKD_ENABLE_RST 24'hc1beff
// lock detect configuration fields
`define LKD_CNT_HI 2
`define LKD_CNT_LO 0
`define LKD_LD_ON 3
`define LKD_WIN_DIGITAL 6
`define LKD_WIN_HI 9
`define LKD_WIN_LO 7
`define LKD_RATE_HI 11
`define LKD_RATE_LO 10
`define LKD_RELOCK_ONCE 13
// enable register fields
`define LKD_EN_BIAS 0
`define LKD_EN_CP 1
`define LKD_EN_PD 2
`define LKD_EN_REFBUF 3
`define LKD_EN_OSCBUF 4
`define LKD_EN_PIN 5
`define LKD_EN_PRESC 10
`define LKD_EN_HIREF 21
// ------------------------------------------------------------
// serial frame: rw, 6-bit address, 3-bit chip address, 24 data
// ------------------------------------------------------------
`define LKD_HDR_LEN 6'd10
`define LKD_FRAME_LEN 6'd34
`define LKD_HDR_RW 9
`define LKD_HDR_ADDR_HI 8
`define LKD_HDR_ADDR_LO 3
`define LKD_HDR_CHIP_HI 2
`define LKD_HDR_CHIP_LO 0
// synchroniser lanes
`define LKD_SY_SCK 0
`define LKD_SY_SEN 1
`define LKD_SY_SDI 2
`define LKD_SY_REF 3
`define LKD_SY_DIV 4
`endif

// ### common/lkd_pkg.sv
// types shared by the lock detect and enable register bank
package lkd_pkg;
    typedef enum logic [1:0] {
        LKD_ST_IDLE = 2'b00,
        LKD_ST_HDR = 2'b01,
        LKD_ST_DATA = 2'b10
    } lkd_state_t;

    typedef struct packed {
        logic [4:0] s1;
        logic [4:0] s2;
        logic [4:0] prev;
        lkd_state_t st;
        logic [5:0] bitcnt;
        logic [9:0] hdr;
        logic [23:0] shin;
        logic [23:0] shout;
        logic [23:0] lock_cfg;
        logic [23:0] en_cfg;
        logic [2:0] presc;
        logic [7:0] elapsed;
        logic armed;
        logic [15:0] cnt;
        logic locked;
        logic relock_used;
        logic relock_start;
        logic pin_data;
        logic pin_oe_b;
    } lkd_state_s_t;
endpackage : lkd_pkg

// ### src/lkd_regs.sv
// lock detector, its configuration registers and the block enables
// ------------------------------------------------------------
// Overview of operation
// - lock after programmed consecutive in-window comparisons, 5 up to 65535
// - bit 3 turns internal lock detection on, reset to one
// - bit 6 picks digital timer window or analog short window
// - bits 9:7 set digital window from half to 64 timer cycles
// - bits 11:10 set timer rate, 00 fastest, 11 slowest
// - bit 13 allows exactly one relock attempt after a lock failure
// - lock configuration register resets to 0x00014d
// - enable register resets to 0xc1beff, all enables active
// - bits 0 to 2 enable bias, charge pump, phase detector
// - bit 3 switches on the reference path buffer
// - bit 4 switches on the oscillator path buffer
// - bit 10 switches on oscillator buffer and prescaler bias
// - clearing bit 5 disables the shared lock and serial out pin
// - bit 5 with always-drive set drives the pin all the time
// - otherwise the pin is released while another chip is addressed
// ------------------------------------------------------------
`include "lkd_defines.svh"

module lkd_regs #(
    parameter logic [2:0] CHIP_ADDR = 3'h0 // own chip address on a shared bus
) (
    input wire logic clk, // 40 MHz block clock
    input wire logic rst_b, // synchronous reset, active low
    input wire logic serial_clock, // serial port clock pin
    input wire logic serial_enable, // serial frame enable pin, high in a frame
    input wire logic serial_data_in, // serial data pin, sampled on rising clock
    input wire logic ref_pulse, // reference side of the phase comparison
    input wire logic div_pulse, // divided oscillator side of the comparison
    input wire logic sdo_always_drive, // register 0x0f bit 7, same clock
    output logic lock_or_serial_out_pin, // shared lock / serial data output
    output logic lock_or_serial_out_oe_b, // low while the pin is driven
    output logic bias_on, // main bias reference enable
    output logic charge_pump_on, // charge pump enable
    output logic phase_detector_on, // phase detector enable
    output logic reference_buffer_on, // reference path buffer enable
    output logic oscillator_buffer_on, // oscillator path buffer enable
    output logic prescaler_bias_on, // oscillator buffer and prescaler bias
    output logic high_freq_reference, // reference range select
    output logic lock_detected, // lock indication
    output logic relock_start // one-cycle relock request
);
    import lkd_pkg::*;

    lkd_state_s_t q;
    lkd_state_s_t n;
    logic [4:0] rise;
    logic [4:0] fall;
    logic [23:0] rd_data;
    logic hdr_match;
    logic [15:0] target;
    logic [7:0] limit;
    logic [2:0] tick_max;
    logic cmp_valid;
    logic cmp_in;
    logic wr_commit;

    // ------------------------------------------------------------
    // decode of configuration fields
    // ------------------------------------------------------------
    // count table
    always_comb begin
        case (q.lock_cfg[`LKD_CNT_HI:`LKD_CNT_LO])
            3'h0: target = 16'h0005;
            3'h1: target = 16'h0020;
            3'h2: target = 16'h0060;
            3'h3: target = 16'h0100;
            3'h4: target = 16'h0200;
            3'h5: target = 16'h0800;
            3'h6: target = 16'h2000;
            3'h7: target = 16'hffff;
            default: target = 16'hffff;
        endcase
    end

    // window length in timer ticks, half cycle means same clock
    always_comb begin
        case (q.lock_cfg[`LKD_WIN_HI:`LKD_WIN_LO])
            3'h0: limit = 8'h00;
            3'h1: limit = 8'h01;
            3'h2: limit = 8'h02;
            3'h3: limit = 8'h04;
            3'h4: limit = 8'h08;
            3'h5: limit = 8'h10;
            3'h6: limit = 8'h20;
            3'h7: limit = 8'h40;
            default: limit = 8'h40;
        endcase
    end

    // timer prescale, a slower timer stretches the same window
    always_comb begin
        case (q.lock_cfg[`LKD_RATE_HI:`LKD_RATE_LO])
            2'h0: tick_max = 3'h0;
            2'h1: tick_max = 3'h1;
            2'h2: tick_max = 3'h3;
            2'h3: tick_max = 3'h7;
            default: tick_max = 3'h7;
        endcase
    end

    // read data for the addressed register, unmapped reads give zero
    always_comb begin
        case (q.hdr[`LKD_HDR_ADDR_HI:`LKD_HDR_ADDR_LO])
            `LKD_ADDR_LOCK: rd_data = q.lock_cfg;
            `LKD_ADDR_ENABLE: rd_data = q.en_cfg;
            default: rd_data = 24'h000000;
        endcase
    end

    assign hdr_match = (q.hdr[`LKD_HDR_CHIP_HI:`LKD_HDR_CHIP_LO] == CHIP_ADDR);
    assign rise = q.s2 & ~q.prev;
    assign fall = ~q.s2 & q.prev;
    assign wr_commit = (q.st == LKD_ST_DATA) && !q.s2[`LKD_SY_SEN]
        && (q.bitcnt == `LKD_FRAME_LEN) && !q.hdr[`LKD_HDR_RW] && hdr_match;

    // ------------------------------------------------------------
    // phase comparison
    // ------------------------------------------------------------
    // a reference edge arms the window; a second reference edge with no
    // divided edge in between counts as a failed comparison
    always_comb begin
        cmp_valid = 1'b0;
        cmp_in = 1'b0;
        if (rise[`LKD_SY_DIV]) begin
            cmp_valid = 1'b1;
            if (rise[`LKD_SY_REF]) begin
                cmp_in = 1'b1;
            end else if (q.lock_cfg[`LKD_WIN_DIGITAL]) begin
                // strictly below: the tick count lags the reference edge by one clock,
                // so a half cycle window accepts only edges in the same clock
                cmp_in = q.armed && (q.elapsed < limit);
            end else begin
                cmp_in = 1'b0;
            end
        end else if (rise[`LKD_SY_REF] && q.armed) begin
            cmp_valid = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        n = q;
        // only the second stage reads the first
        n.s1 = {div_pulse, ref_pulse, serial_data_in, serial_enable, serial_clock};
        n.s2 = q.s1;
        n.prev = q.s2;
        n.relock_start = 1'b0;

        // serial frame engine
        case (q.st)
            LKD_ST_IDLE: begin
                if (rise[`LKD_SY_SEN]) begin
                    n.st = LKD_ST_HDR;
                    n.bitcnt = 6'd0;
                end
            end
            LKD_ST_HDR: begin
                if (rise[`LKD_SY_SCK]) begin
                    n.bitcnt = q.bitcnt + 6'd1;
                    n.hdr = {q.hdr[8:0], q.s2[`LKD_SY_SDI]};
                    if (q.bitcnt + 6'd1 == `LKD_HDR_LEN) begin
                        n.st = LKD_ST_DATA;
                    end
                end
            end
            LKD_ST_DATA: begin
                if (rise[`LKD_SY_SCK] && q.bitcnt != `LKD_FRAME_LEN) begin
                    n.bitcnt = q.bitcnt + 6'd1;
                    n.shin = {q.shin[22:0], q.s2[`LKD_SY_SDI]};
                end
                // first falling edge after the header loads, later ones shift
                if (fall[`LKD_SY_SCK]) begin
                    if (q.bitcnt == `LKD_HDR_LEN) begin
                        n.shout = rd_data;
                    end else begin
                        n.shout = {q.shout[22:0], 1'b0};
                    end
                end
            end
            default: begin
                n.st = LKD_ST_IDLE;
            end
        endcase

        // frame end; short or foreign frames change nothing
        if (q.st != LKD_ST_IDLE && !q.s2[`LKD_SY_SEN]) begin
            n.st = LKD_ST_IDLE;
        end
        if (wr_commit) begin
            case (q.hdr[`LKD_HDR_ADDR_HI:`LKD_HDR_ADDR_LO])
                `LKD_ADDR_LOCK: begin
                    n.lock_cfg = q.shin;
                    // reprogramming rearms the single relock attempt
                    n.relock_used = 1'b0;
                end
                `LKD_ADDR_ENABLE: n.en_cfg = q.shin;
                default: n.st = LKD_ST_IDLE;
            endcase
        end

        // window timer runs from the last reference edge, saturating
        if (q.presc == tick_max) begin
            n.presc = 3'h0;
            if (q.elapsed != 8'hff) begin
                n.elapsed = q.elapsed + 8'h01;
            end
        end else begin
            n.presc = q.presc + 3'h1;
        end
        if (rise[`LKD_SY_REF] && !rise[`LKD_SY_DIV]) begin
            n.armed = 1'b1;
            n.elapsed = 8'h00;
            n.presc = 3'h0;
        end else if (rise[`LKD_SY_DIV]) begin
            n.armed = 1'b0;
        end

        if (!q.lock_cfg[`LKD_LD_ON]) begin
            n.cnt = 16'h0000;
            n.locked = 1'b0;
            n.armed = 1'b0;
        end else if (cmp_valid && cmp_in) begin
            if (q.cnt != target) begin
                n.cnt = q.cnt + 16'h0001;
            end
            n.locked = ({1'b0, q.cnt} + 17'h00001) >= {1'b0, target};
        end else if (cmp_valid) begin
            n.cnt = 16'h0000;
            n.locked = 1'b0;
            if (q.locked && q.lock_cfg[`LKD_RELOCK_ONCE] && !q.relock_used) begin
                n.relock_start = 1'b1;
                n.relock_used = 1'b1;
            end
        end

        // shared pin: read data during a matched read, lock otherwise
        n.pin_data = (q.st == LKD_ST_DATA && q.hdr[`LKD_HDR_RW] && hdr_match)
            ? q.shout[23] : q.locked;
        if (!q.en_cfg[`LKD_EN_PIN]) begin
            n.pin_oe_b = 1'b1;
        end else if (sdo_always_drive) begin
            n.pin_oe_b = 1'b0;
        end else begin
            n.pin_oe_b = (q.st == LKD_ST_DATA) && !hdr_match;
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '0;
            q.st <= LKD_ST_IDLE;
            q.lock_cfg <= `LKD_LOCK_RST;
            q.en_cfg <= `LKD_ENABLE_RST;
            q.pin_oe_b <= 1'b1;
        end else begin
            q <= n;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flops
    // ------------------------------------------------------------
    assign bias_on = q.en_cfg[`LKD_EN_BIAS];
    assign charge_pump_on = q.en_cfg[`LKD_EN_CP];
    assign phase_detector_on = q.en_cfg[`LKD_EN_PD];
    assign reference_buffer_on = q.en_cfg[`LKD_EN_REFBUF];
    assign oscillator_buffer_on = q.en_cfg[`LKD_EN_OSCBUF];
    assign prescaler_bias_on = q.en_cfg[`LKD_EN_PRESC];
    assign high_freq_reference = q.en_cfg[`LKD_EN_HIREF];
    assign lock_detected = q.locked;
    assign relock_start = q.relock_start;
    assign lock_or_serial_out_pin = q.pin_data;
    assign lock_or_serial_out_oe_b = q.pin_oe_b;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    lock_reached_a: assert property (
        q.lock_cfg[`LKD_LD_ON] && cmp_valid && cmp_in && q.cnt + 16'h0001 == target
        |=> q.locked && q.cnt == $past(target))
        else $error("lock not declared at target count");

    miss_clears_a: assert property (
        q.lock_cfg[`LKD_LD_ON] && cmp_valid && !cmp_in |=> !q.locked && q.cnt == 16'h0000)
        else $error("miss did not clear lock");

    detect_off_a: assert property (
        !q.lock_cfg[`LKD_LD_ON] |=> !lock_detected && q.cnt == 16'h0000)
        else $error("lock seen while detector off");

    relock_once_a: assert property (
        relock_start |-> q.relock_used && !$past(q.relock_used)
        && $past(q.locked) && !q.locked)
        else $error("relock not a single attempt");

    reset_values_a: assert property (
        $rose(rst_b) |-> q.lock_cfg == `LKD_LOCK_RST && q.en_cfg == `LKD_ENABLE_RST)
        else $error("bad register reset values");

    enable_write_a: assert property (
        wr_commit && q.hdr[`LKD_HDR_ADDR_HI:`LKD_HDR_ADDR_LO] == `LKD_ADDR_ENABLE
        |=> q.en_cfg == $past(q.shin) && bias_on == $past(q.shin[`LKD_EN_BIAS])
        && charge_pump_on == $past(q.shin[`LKD_EN_CP]))
        else $error("enable write lost");

    pin_off_a: assert property (
        !q.en_cfg[`LKD_EN_PIN] |=> lock_or_serial_out_oe_b)
        else $error("pin driven while disabled");

    pin_always_a: assert property (
        q.en_cfg[`LKD_EN_PIN] && sdo_always_drive |=> !lock_or_serial_out_oe_b)
        else $error("pin not driven in always mode");

    pin_shared_a: assert property (
        q.en_cfg[`LKD_EN_PIN] && !sdo_always_drive && q.st == LKD_ST_DATA && !hdr_match
        |=> lock_or_serial_out_oe_b)
        else $error("pin driven for foreign chip");

    lock_cover_c: cover property ($rose(q.locked));
    relock_cover_c: cover property (relock_start);
    read_cover_c: cover property (q.st == LKD_ST_DATA && q.hdr[`LKD_HDR_RW] && hdr_match);
    write_cover_c: cover property (wr_commit);

endmodule : lkd_regs

// ### tb/lkd_host.sv
// serial host model that programs and reads the lock detect register bank
module lkd_host (
    input wire logic clk, // block clock, paces the serial timing
    output logic sck, // serial clock, still outside frames
    output logic sen, // frame enable, high in a frame
    output logic sdi, // serial data toward the bank
    input wire logic pin, // shared lock / serial out pin
    input wire logic pin_oe_b // low while the bank drives the pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sck = 1'b0;
        sen = 1'b0;
        sdi = 1'b0;
    end

    // ------------------------------------------------------------
    // frame: n bits msb first, 100 ns per half period
    // ------------------------------------------------------------
    // samples at the end of each data bit high phase, where read data has settled
    task automatic frame(input logic [33:0] word, input int n,
                         output logic [23:0] rdata, output logic released);
        rdata = 24'h000000;
        released = 1'b1;
        @(posedge clk) sen <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < n; i++) begin
            sdi <= word[33 - i];
            repeat (4) @(posedge clk);
            sck <= 1'b1;
            repeat (4) @(posedge clk);
            if (i >= 10) begin
                // a released pin has no keeper, so it reads as the inverse
                rdata[33 - i] = pin_oe_b ? ~pin : pin;
                released = released & pin_oe_b;
            end
            sck <= 1'b0;
        end
        repeat (4) @(posedge clk);
        sen <= 1'b0;
        // idle data line must not keep the last bit
        sdi <= ~sdi;
        repeat (8) @(posedge clk);
    endtask : frame
endmodule : lkd_host

// ### tb/testbench.sv
// self-checking bench for the lock detect and enable register bank
`include "lkd_defines.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end

module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_b, sck, sen, sdi, ref_pulse, div_pulse, always_drive;
    logic pin, oe_b, bias, cp, pd, refbuf, oscbuf, presc, hiref, locked, relock;
    int err_total = 0;
    int check_count = 0;
    int relock_cnt = 0;
    logic [23:0] rd;
    logic rel;

    lkd_regs #(.CHIP_ADDR(3'h0)) dut_u (.clk(clk), .rst_b(rst_b), .serial_clock(sck),
        .serial_enable(sen), .serial_data_in(sdi), .ref_pulse(ref_pulse),
        .div_pulse(div_pulse), .sdo_always_drive(always_drive),
        .lock_or_serial_out_pin(pin), .lock_or_serial_out_oe_b(oe_b), .bias_on(bias),
        .charge_pump_on(cp), .phase_detector_on(pd), .reference_buffer_on(refbuf),
        .oscillator_buffer_on(oscbuf), .prescaler_bias_on(presc),
        .high_freq_reference(hiref), .lock_detected(locked), .relock_start(relock));
    lkd_host host_u (.clk(clk), .sck(sck), .sen(sen), .sdi(sdi), .pin(pin), .pin_oe_b(oe_b));

    // 40 MHz block clock
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // relock pulses are single cycles, so count them as they pass
    always @(posedge clk) begin
        if (relock === 1'b1) relock_cnt <= relock_cnt + 1;
    end

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim
    task automatic wr(input logic [5:0] a, input logic [23:0] d, input logic [2:0] c);
        host_u.frame({1'b0, a, c, d}, 34, rd, rel);
    endtask : wr
    task automatic rdreg(input logic [5:0] a, input logic [2:0] c, input logic [23:0] e,
                         input logic e_rel);
        host_u.frame({1'b1, a, c, 24'h000000}, 34, rd, rel);
        if (c == 3'h0) `CHK(rd, e)
        `CHK(rel, e_rel)
    endtask : rdreg
    task automatic chk_en(input logic [23:0] v);
        `CHK({hiref, presc, oscbuf, refbuf, pd, cp, bias}, {v[21], v[10], v[4:0]})
    endtask : chk_en
    // one comparison, divided edge gap clocks after the reference edge
    task automatic cmp(input int gap);
        @(posedge clk) ref_pulse <= 1'b1;
        if (gap == 0) div_pulse <= 1'b1;
        repeat (gap) @(posedge clk);
        if (gap != 0) div_pulse <= 1'b1;
        repeat (4) @(posedge clk);
        ref_pulse <= 1'b0;
        div_pulse <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : cmp
    // a divided edge with no reference edge armed is a miss
    task automatic miss;
        @(posedge clk) div_pulse <= 1'b1;
        repeat (4) @(posedge clk);
        div_pulse <= 1'b0;
        repeat (6) @(posedge clk);
    endtask : miss
    // clear the count, give four comparisons, then the fifth that reaches target 5
    task automatic lock_run(input logic [23:0] cfg, input int gap, input logic e);
        wr(`LKD_ADDR_LOCK, cfg, 3'h0);
        miss;
        repeat (4) cmp(gap);
        `CHK(locked, 1'b0)
        cmp(gap);
        `CHK({locked, pin}, {e, e})
    endtask : lock_run

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset;
        chk_en(`LKD_ENABLE_RST);
        `CHK({locked, relock, oe_b}, 3'b000)
        rdreg(`LKD_ADDR_LOCK, 3'h0, `LKD_LOCK_RST, 1'b0);
        rdreg(`LKD_ADDR_ENABLE, 3'h0, `LKD_ENABLE_RST, 1'b0);
    endtask : t_reset
    task automatic t_enables;
        int bits[6] = '{0, 1, 2, 3, 4, 10};
        logic [23:0] v;
        // read-modify-write from the reset image keeps reserved fields intact
        foreach (bits[k]) begin
            v = `LKD_ENABLE_RST ^ (24'h000001 << bits[k]);
            wr(`LKD_ADDR_ENABLE, v, 3'h0);
            chk_en(v);
        end
        v = `LKD_ENABLE_RST | 24'h200000;
        wr(`LKD_ADDR_ENABLE, v, 3'h0);
        chk_en(v);
        wr(`LKD_ADDR_ENABLE, 24'h000000, 3'h5);
        chk_en(v);
        rdreg(6'h20, 3'h0, 24'h000000, 1'b0);
        wr(`LKD_ADDR_ENABLE, `LKD_ENABLE_RST, 3'h0);
    endtask : t_enables
    task automatic t_pin;
        @(posedge clk) always_drive <= 1'b0;
        rdreg(`LKD_ADDR_LOCK, 3'h0, `LKD_LOCK_RST, 1'b0);
        rdreg(`LKD_ADDR_LOCK, 3'h5, 24'h000000, 1'b1);
        wr(`LKD_ADDR_ENABLE, `LKD_ENABLE_RST & 24'hffffdf, 3'h0);
        `CHK(oe_b, 1'b1)
        @(posedge clk) always_drive <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(oe_b, 1'b1)
        wr(`LKD_ADDR_ENABLE, `LKD_ENABLE_RST, 3'h0);
        `CHK(oe_b, 1'b0)
    endtask : t_pin
    task automatic t_lock;
        lock_run(24'h000148, 0, 1'b1);
        miss;
        `CHK(locked, 1'b0)
        lock_run(24'h000148, 1, 1'b1);
        lock_run(24'h000148, 6, 1'b0);
        lock_run(24'h000048, 1, 1'b0);
        lock_run(24'h0003c8, 20, 1'b1);
        lock_run(24'h000108, 1, 1'b0);
        lock_run(24'h000108, 0, 1'b1);
        lock_run(24'h000d48, 6, 1'b1);
        lock_run(24'h000140, 0, 1'b0);
    endtask : t_lock
    task automatic t_relock;
        int c0;
        c0 = relock_cnt;
        lock_run(24'h002148, 0, 1'b1);
        miss;
        `CHK(relock_cnt, c0 + 1)
        repeat (5) cmp(0);
        miss;
        `CHK(relock_cnt, c0 + 1)
    endtask : t_relock
    // a reset in mid-run must bring both registers back to their defaults
    task automatic t_rereset;
        wr(`LKD_ADDR_ENABLE, 24'h000000, 3'h0);
        chk_en(24'h000000);
        rst_b <= 1'b0;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        chk_en(`LKD_ENABLE_RST);
        `CHK({locked, oe_b}, 2'b00)
        rdreg(`LKD_ADDR_LOCK, 3'h0, `LKD_LOCK_RST, 1'b0);
    endtask : t_rereset

    // ------------------------------------------------------------
    // main sequence and hang guard
    // ------------------------------------------------------------
    initial begin
        rst_b = 1'b0;
        ref_pulse = 1'b0;
        div_pulse = 1'b0;
        always_drive = 1'b1;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_reset;
        t_enables;
        t_pin;
        t_lock;
        t_relock;
        t_rereset;
        end_sim;
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_total++;
        $display("[FAIL] %0t run did not finish", $time);
        end_sim;
    end
endmodule : testbench
